// [hdl/ppc_params.svh]
// offsets, field positions, reset values and nvm bit positions
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH
// ============================================================
// ============================================================
// register byte addresses
`define PPC_OFF_POWER 16'h0e14
`define PPC_OFF_CONFIG 16'h0e38
`define PPC_OFF_IRQ_STATUS 16'h0e40
`define PPC_OFF_IRQ_ENABLE 16'h0e44
`define PPC_OFF_IRQ_CLEAR 16'h0e48
// reset values
`define PPC_RST_CONFIG 4'hc
`define PPC_RST_POWER 10'h08d
`define PPC_RST_IRQ 2'h0
// power register field positions
`define PPC_PWR_ENERGY 4
`define PPC_PWR_RST_DONE 8
// nvm word bit positions
`define PPC_NVM3_XOVER 9
`define PPC_NVM4_SPD 0
`define PPC_NVM4_LOW_POWER_SPEED_REDUCE 1
`define PPC_NVMP_DIS1000_LP 0
`define PPC_NVMP_GIGA_DIS 1
`define PPC_NVMP_DIS100_LP 2
// axi responses
`define PPC_RESP_OKAY 2'h0
`define PPC_RESP_SLVERR 2'h2
`endif

// [hdl/ppc_pkg.sv]
// types shared by the phy power and config register block
package ppc_pkg;
    typedef enum logic [1:0] {
        PPC_WR_IDLE = 2'b01,
        PPC_WR_RESP = 2'b10
    } ppc_wr_state_type;

    typedef enum logic [1:0] {
        PPC_RD_IDLE = 2'b01,
        PPC_RD_RESP = 2'b10
    } ppc_rd_state_type;

    typedef struct packed {
        logic auto_crossover;
        logic ten_base_te;
        logic advertise_eee_fast;
        logic advertise_eee_gigabit;
        logic smart_power_down_enable;
        logic smart_power_down_back_to_back;
        logic link_disconnect;
        logic low_speed_link;
        logic gigabit_allowed;
        logic fast_allowed;
    } ppc_phy_ctrl_type;
endpackage

// [hdl/ppc_regs.sv]
// phy power and configuration registers behind an axi4-lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "ppc_params.svh"

module ppc_regs import ppc_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [15:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [15:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // nvm loader, same clock
    input wire logic nvm_load,
    input wire logic [15:0] nvm_init_ctrl3,
    input wire logic [15:0] nvm_init_ctrl4,
    input wire logic [15:0] nvm_pin_ctrl,
    // phy status, asynchronous
    input wire logic link_energy,
    input wire logic phy_reset_done,
    // power state, same clock
    input wire logic power_state_full,
    // phy control
    output ppc_phy_ctrl_type phy_ctrl,
    output logic eee_renegotiate,
    // interrupt
    output logic irq
);

    // ============================================================
    // state
    ppc_wr_state_type wr_state_reg;
    ppc_wr_state_type wr_state_next;
    ppc_rd_state_type rd_state_reg;
    ppc_rd_state_type rd_state_next;
    logic aw_full_reg;
    logic aw_full_next;
    logic w_full_reg;
    logic w_full_next;
    logic [15:0] wr_addr_reg;
    logic [15:0] wr_addr_next;
    logic [31:0] wr_data_reg;
    logic [31:0] wr_data_next;
    logic [3:0] wr_strb_reg;
    logic [3:0] wr_strb_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [3:0] cfg_reg;
    logic [3:0] cfg_next;
    logic [9:0] pwr_reg;
    logic [9:0] pwr_next;
    logic energy_latch_reg;
    logic energy_latch_next;
    logic rst_latch_reg;
    logic rst_latch_next;
    logic [1:0] sync1_reg;
    logic [1:0] sync1_next;
    logic [1:0] sync2_reg;
    logic [1:0] sync2_next;
    logic [1:0] prev_reg;
    logic [1:0] prev_next;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_status_next;
    logic [1:0] irq_enable_reg;
    logic [1:0] irq_enable_next;
    ppc_phy_ctrl_type phy_ctrl_reg;
    ppc_phy_ctrl_type phy_ctrl_next;
    logic reneg_reg;
    logic reneg_next;
    logic irq_reg;
    logic irq_next;

    // ============================================================
    // register word indices
    localparam logic [13:0] idx_pwr = 14'(`PPC_OFF_POWER >> 2);
    localparam logic [13:0] idx_cfg = 14'(`PPC_OFF_CONFIG >> 2);
    localparam logic [13:0] idx_irq_sts = 14'(`PPC_OFF_IRQ_STATUS >> 2);
    localparam logic [13:0] idx_irq_ena = 14'(`PPC_OFF_IRQ_ENABLE >> 2);
    localparam logic [13:0] idx_irq_clr = 14'(`PPC_OFF_IRQ_CLEAR >> 2);

    // ============================================================
    // byte lane mask
    logic [31:0] wmask;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_mask
            assign wmask[gi*8 +: 8] = {8{wr_strb_reg[gi]}};
        end
    endgenerate

    // ============================================================
    // handshake and other outputs
    assign awready = (wr_state_reg == PPC_WR_IDLE) && !aw_full_reg;
    assign wready = (wr_state_reg == PPC_WR_IDLE) && !w_full_reg;
    assign bvalid = (wr_state_reg == PPC_WR_RESP);
    assign arready = (rd_state_reg == PPC_RD_IDLE);
    assign rvalid = (rd_state_reg == PPC_RD_RESP);
    assign bresp = bresp_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign phy_ctrl = phy_ctrl_reg;
    assign eee_renegotiate = reneg_reg;
    assign irq = irq_reg;

    // ============================================================
    // next state
    logic commit;
    logic hit_cfg;
    logic hit_pwr;
    logic hit_sts;
    logic hit_ena;
    logic hit_clr;
    logic rd_pwr;
    logic [31:0] merged;
    logic [1:0] rise;
    logic [1:0] irq_clear;
    logic non_full;

    always_comb begin
        wr_state_next = wr_state_reg;
        rd_state_next = rd_state_reg;
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        wr_strb_next = wr_strb_reg;
        bresp_next = bresp_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        cfg_next = cfg_reg;
        pwr_next = pwr_reg;
        irq_enable_next = irq_enable_reg;
        irq_clear = 2'h0;
        reneg_next = 1'b0;
        merged = 32'h0000_0000;
        commit = 1'b0;

        // synchronisers and edges
        sync1_next = {phy_reset_done, link_energy};
        sync2_next = sync1_reg;
        prev_next = sync2_reg;
        rise = sync2_reg & ~prev_reg;

        // address and data capture, either order
        if (awvalid && awready) begin
            aw_full_next = 1'b1;
            wr_addr_next = awaddr;
        end
        if (wvalid && wready) begin
            w_full_next = 1'b1;
            wr_data_next = wdata;
            wr_strb_next = wstrb;
        end

        hit_cfg = wr_addr_reg[15:2] == idx_cfg;
        hit_pwr = wr_addr_reg[15:2] == idx_pwr;
        hit_sts = wr_addr_reg[15:2] == idx_irq_sts;
        hit_ena = wr_addr_reg[15:2] == idx_irq_ena;
        hit_clr = wr_addr_reg[15:2] == idx_irq_clr;

        // nvm reload of the loadable defaults
        // a bus write in the same cycle overrides these
        if (nvm_load) begin
            cfg_next[0] = nvm_init_ctrl3[`PPC_NVM3_XOVER];
            pwr_next[0] = nvm_init_ctrl4[`PPC_NVM4_SPD];
            pwr_next[2] = nvm_init_ctrl4[`PPC_NVM4_LOW_POWER_SPEED_REDUCE];
            pwr_next[3] = nvm_pin_ctrl[`PPC_NVMP_DIS1000_LP];
            pwr_next[6] = nvm_pin_ctrl[`PPC_NVMP_GIGA_DIS];
            pwr_next[9] = nvm_pin_ctrl[`PPC_NVMP_DIS100_LP];
        end

        case (wr_state_reg)
            PPC_WR_IDLE: begin
                if (aw_full_reg && w_full_reg) begin
                    commit = 1'b1;
                    wr_state_next = PPC_WR_RESP;
                    bresp_next = `PPC_RESP_OKAY;
                    if (hit_cfg) begin
                        merged = ({28'h000_0000, cfg_reg} & ~wmask)
                            | (wr_data_reg & wmask);
                        // reserved bits are dropped
                        cfg_next = merged[3:0];
                        if (merged[3:2] != cfg_reg[3:2]) begin
                            reneg_next = 1'b1;
                        end
                    end else if (hit_pwr) begin
                        merged = ({22'h00_0000, pwr_reg} & ~wmask)
                            | (wr_data_reg & wmask);
                        pwr_next = merged[9:0];
                        pwr_next[`PPC_PWR_ENERGY] = 1'b0;
                        pwr_next[`PPC_PWR_RST_DONE] = 1'b0;
                    end else if (hit_ena) begin
                        merged = ({30'h0000_0000, irq_enable_reg}
                            & ~wmask) | (wr_data_reg & wmask);
                        irq_enable_next = merged[1:0];
                    end else if (hit_clr) begin
                        // write one clears, byte lane 0 only
                        if (wr_strb_reg[0]) begin
                            irq_clear = wr_data_reg[1:0];
                        end
                    end else if (!hit_sts) begin
                        bresp_next = `PPC_RESP_SLVERR;
                    end
                end
            end
            PPC_WR_RESP: begin
                if (bready) begin
                    wr_state_next = PPC_WR_IDLE;
                    aw_full_next = 1'b0;
                    w_full_next = 1'b0;
                end
            end
            default: begin
                wr_state_next = PPC_WR_IDLE;
                aw_full_next = 1'b0;
                w_full_next = 1'b0;
            end
        endcase

        // read channel
        rd_pwr = 1'b0;
        case (rd_state_reg)
            PPC_RD_IDLE: begin
                if (arvalid) begin
                    rd_state_next = PPC_RD_RESP;
                    rresp_next = `PPC_RESP_OKAY;
                    rdata_next = 32'h0000_0000;
                    case (araddr[15:2])
                        idx_cfg: begin
                            rdata_next[3:0] = cfg_reg;
                        end
                        idx_pwr: begin
                            rd_pwr = 1'b1;
                            rdata_next[9:0] = pwr_reg;
                            rdata_next[`PPC_PWR_ENERGY] =
                                energy_latch_reg | pwr_reg[5];
                            rdata_next[`PPC_PWR_RST_DONE] =
                                rst_latch_reg;
                        end
                        idx_irq_sts: begin
                            rdata_next[1:0] = irq_status_reg;
                        end
                        idx_irq_ena: begin
                            rdata_next[1:0] = irq_enable_reg;
                        end
                        idx_irq_clr: begin
                            rdata_next = 32'h0000_0000;
                        end
                        default: begin
                            rresp_next = `PPC_RESP_SLVERR;
                        end
                    endcase
                end
            end
            PPC_RD_RESP: begin
                if (rready) begin
                    rd_state_next = PPC_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = PPC_RD_IDLE;
            end
        endcase

        // latched-high flags, set wins over read clear
        energy_latch_next = (energy_latch_reg & ~rd_pwr)
            | sync2_reg[0];
        rst_latch_next = (rst_latch_reg & ~rd_pwr)
            | sync2_reg[1];

        // sticky interrupt status, set wins over clear
        // status bit 0 energy edge, bit 1 reset-done edge
        irq_status_next = (irq_status_reg & ~irq_clear) | rise;
        irq_next = |(irq_status_next & irq_enable_next);

        // phy controls follow the new register values
        non_full = !power_state_full;
        phy_ctrl_next.auto_crossover = cfg_next[0];
        phy_ctrl_next.ten_base_te = cfg_next[1];
        phy_ctrl_next.advertise_eee_fast = cfg_next[2];
        phy_ctrl_next.advertise_eee_gigabit = cfg_next[3];
        phy_ctrl_next.smart_power_down_enable = pwr_next[0];
        phy_ctrl_next.smart_power_down_back_to_back =
            pwr_next[7];
        phy_ctrl_next.link_disconnect = pwr_next[5];
        phy_ctrl_next.low_speed_link = pwr_next[1]
            | (non_full & pwr_next[2]);
        phy_ctrl_next.gigabit_allowed = !pwr_next[6]
            && !(non_full && pwr_next[3])
            && !(non_full && pwr_next[9]);
        phy_ctrl_next.fast_allowed =
            !(non_full && pwr_next[9]);
    end

    // ============================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= PPC_WR_IDLE;
            rd_state_reg <= PPC_RD_IDLE;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            wr_addr_reg <= 16'h0000;
            wr_data_reg <= 32'h0000_0000;
            wr_strb_reg <= 4'h0;
            bresp_reg <= `PPC_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `PPC_RESP_OKAY;
            cfg_reg <= `PPC_RST_CONFIG;
            pwr_reg <= `PPC_RST_POWER;
            energy_latch_reg <= 1'b0;
            rst_latch_reg <= 1'b0;
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            prev_reg <= 2'h0;
            irq_status_reg <= `PPC_RST_IRQ;
            irq_enable_reg <= `PPC_RST_IRQ;
            phy_ctrl_reg <= '0;
            reneg_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            wr_state_reg <= wr_state_next;
            rd_state_reg <= rd_state_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            wr_strb_reg <= wr_strb_next;
            bresp_reg <= bresp_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            cfg_reg <= cfg_next;
            pwr_reg <= pwr_next;
            energy_latch_reg <= energy_latch_next;
            rst_latch_reg <= rst_latch_next;
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg <= prev_next;
            irq_status_reg <= irq_status_next;
            irq_enable_reg <= irq_enable_next;
            phy_ctrl_reg <= phy_ctrl_next;
            reneg_reg <= reneg_next;
            irq_reg <= irq_next;
        end
    end

endmodule

// [verif/ppc_regs_chk.sv]
// assertion checker for the phy power and config registers
`timescale 1ns/1ps
`include "ppc_params.svh"
module ppc_regs_chk import ppc_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // phy side
    input wire logic power_state_full,
    input wire ppc_phy_ctrl_type phy_ctrl,
    input wire logic eee_renegotiate,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ============================================================
    // last read address was the power register
    logic rd_pwr_reg;
    logic rd_pwr_next;
    always_comb begin
        rd_pwr_next = rd_pwr_reg;
        if (arvalid && arready) begin
            rd_pwr_next = (araddr[15:2] == 14'h0385);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pwr_reg <= 1'b0;
        end else begin
            rd_pwr_reg <= rd_pwr_next;
        end
    end
    // ============================================================
    // properties
    wr_answer_a: assert property (awvalid && awready && wvalid && wready
        |-> ##2 bvalid) else $error("write response late");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read response late");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("second read accepted");
    eee_reneg_a: assert property ($past(aresetn, 2) &&
        ($changed(phy_ctrl.advertise_eee_fast) ||
        $changed(phy_ctrl.advertise_eee_gigabit)) |-> eee_renegotiate)
        else $error("advertisement change without renegotiation");
    disc_now_a: assert property ($rose(phy_ctrl.link_disconnect)
        |-> $rose(bvalid)) else $error("disconnect not tied to write");
    energy_forced_a: assert property ($rose(rvalid) && rd_pwr_reg &&
        $past(phy_ctrl.link_disconnect) |-> rdata[4])
        else $error("energy flag low while disconnected");
    fast_full_a: assert property ($past(aresetn) &&
        $past(power_state_full) |-> phy_ctrl.fast_allowed)
        else $error("fast speed blocked in full power");
    wr_c: cover property (bvalid && bready);
    reneg_c: cover property (eee_renegotiate);
    irq_c: cover property ($rose(irq));
endmodule

bind ppc_regs ppc_regs_chk chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .power_state_full(power_state_full),
    .phy_ctrl(phy_ctrl), .eee_renegotiate(eee_renegotiate), .irq(irq));

// [verif/ppc_phy_model.sv]
// stand-in for the phy and cable side: energy and reset-done levels
`timescale 1ns/1ps
module ppc_phy_model import ppc_pkg::*; (
    // clock and commands
    input wire logic aclk,
    input wire logic energy_cmd,
    input wire logic boot_cmd,
    // block side
    input wire ppc_phy_ctrl_type phy_ctrl,
    output logic link_energy,
    output logic phy_reset_done
);
    always @(posedge aclk) begin
        // a disconnected phy senses no line energy
        link_energy <= energy_cmd && !phy_ctrl.link_disconnect;
        phy_reset_done <= boot_cmd;
    end
endmodule

// [verif/ppc_regs_bench.sv]
// self-checking bench for the phy power and config registers
`timescale 1ns/1ps
`include "ppc_params.svh"
module ppc_regs_bench import ppc_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, eee_renegotiate;
    logic [1:0] bresp, rresp, last_resp;
    logic [31:0] rdata, last_data;
    logic nvm_load = 1'b0, power_state_full = 1'b1;
    logic energy_cmd = 1'b0, boot_cmd = 1'b0;
    logic [15:0] nvm3 = '0, nvm4 = '0, nvmp = '0;
    logic link_energy, phy_reset_done;
    ppc_phy_ctrl_type phy_ctrl;
    int fail_count = 0;
    int tests_run = 0;
    int reneg_count = 0;
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (eee_renegotiate === 1'b1) begin
            reneg_count <= reneg_count + 1;
        end
    end
    ppc_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .nvm_load(nvm_load),
        .nvm_init_ctrl3(nvm3), .nvm_init_ctrl4(nvm4), .nvm_pin_ctrl(nvmp),
        .link_energy(link_energy), .phy_reset_done(phy_reset_done),
        .power_state_full(power_state_full), .phy_ctrl(phy_ctrl),
        .eee_renegotiate(eee_renegotiate), .irq(irq));
    ppc_phy_model phy (.aclk(aclk), .energy_cmd(energy_cmd),
        .boot_cmd(boot_cmd), .phy_ctrl(phy_ctrl), .link_energy(link_energy),
        .phy_reset_done(phy_reset_done));
    // ============================================================
    // reporting
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic pend_chk(input logic pend);
        if (pend) begin
            fail_count++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            end_sim();
        end
    endtask
    // ============================================================
    // bus master
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
        int n;
        logic aw_p, w_p, b_p;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        b_p = 1'b1;
        n = 0;
        while (b_p && n < 50) begin
            @(posedge aclk);
            n++;
            if (aw_p && awready) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && wready) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
            if (bvalid) begin
                last_resp = bresp;
                bready <= 1'b0;
                b_p = 1'b0;
            end
        end
        pend_chk(b_p);
    endtask
    task automatic axi_rd(input logic [15:0] a);
        int n;
        logic ar_p, r_p;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_p = 1'b1;
        r_p = 1'b1;
        n = 0;
        while (r_p && n < 50) begin
            @(posedge aclk);
            n++;
            if (ar_p && arready) begin
                arvalid <= 1'b0;
                ar_p = 1'b0;
            end
            if (rvalid) begin
                last_data = rdata;
                last_resp = rresp;
                rready <= 1'b0;
                r_p = 1'b0;
            end
        end
        pend_chk(r_p);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        axi_rd(a);
        check(last_data, e);
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset();
        rd_chk(`PPC_OFF_CONFIG, 32'h0000_000c);
        rd_chk(`PPC_OFF_POWER, 32'h0000_008d);
        check(phy_ctrl.advertise_eee_gigabit, 1'b1);
        check(phy_ctrl.smart_power_down_back_to_back, 1'b1);
        $display("reset values done");
    endtask
    task automatic t_nvm();
        nvm3 <= 16'h0200;
        nvmp <= 16'h0007;
        nvm_load <= 1'b1;
        @(posedge aclk);
        nvm_load <= 1'b0;
        rd_chk(`PPC_OFF_CONFIG, 32'h0000_000d);
        rd_chk(`PPC_OFF_POWER, 32'h0000_02c8);
        check(phy_ctrl.gigabit_allowed, 1'b0);
        check(phy_ctrl.auto_crossover, 1'b1);
        check(phy_ctrl.smart_power_down_enable, 1'b0);
        axi_wr(`PPC_OFF_POWER, 32'h0000_008d);
        $display("nvm load done");
    endtask
    task automatic t_eee();
        int n0;
        n0 = reneg_count;
        axi_wr(`PPC_OFF_CONFIG, 32'h0000_0009);
        @(posedge aclk);
        check(reneg_count - n0, 1);
        check(phy_ctrl.advertise_eee_fast, 1'b0);
        n0 = reneg_count;
        axi_wr(`PPC_OFF_CONFIG, 32'h0000_000b);
        @(posedge aclk);
        check(reneg_count - n0, 0);
        check(phy_ctrl.ten_base_te, 1'b1);
        axi_wr(`PPC_OFF_CONFIG, 32'h0000_0001);
        check(phy_ctrl.advertise_eee_gigabit, 1'b0);
        axi_wr(`PPC_OFF_CONFIG, 32'h0000_000d);
        $display("eee advertisement done");
    endtask
    task automatic t_power();
        axi_wr(`PPC_OFF_POWER, 32'h0000_0002);
        check(phy_ctrl.low_speed_link, 1'b1);
        power_state_full <= 1'b0;
        axi_wr(`PPC_OFF_POWER, 32'h0000_020c);
        check(phy_ctrl.low_speed_link, 1'b1);
        check(phy_ctrl.gigabit_allowed, 1'b0);
        check(phy_ctrl.fast_allowed, 1'b0);
        power_state_full <= 1'b1;
        repeat (2) @(posedge aclk);
        check(phy_ctrl.fast_allowed, 1'b1);
        check(phy_ctrl.low_speed_link, 1'b0);
        axi_wr(`PPC_OFF_POWER, 32'h0000_008d);
        $display("power bits done");
    endtask
    task automatic t_latch_irq();
        axi_wr(`PPC_OFF_IRQ_CLEAR, 32'h0000_0003);
        axi_wr(`PPC_OFF_IRQ_ENABLE, 32'h0000_0001);
        energy_cmd <= 1'b1;
        repeat (8) @(posedge aclk);
        check(irq, 1'b1);
        energy_cmd <= 1'b0;
        repeat (8) @(posedge aclk);
        rd_chk(`PPC_OFF_POWER, 32'h0000_009d);
        rd_chk(`PPC_OFF_POWER, 32'h0000_008d);
        axi_wr(`PPC_OFF_IRQ_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        axi_wr(`PPC_OFF_IRQ_ENABLE, 32'h0000_0001);
        axi_wr(`PPC_OFF_IRQ_CLEAR, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        boot_cmd <= 1'b1;
        repeat (8) @(posedge aclk);
        rd_chk(`PPC_OFF_POWER, 32'h0000_018d);
        rd_chk(`PPC_OFF_IRQ_STATUS, 32'h0000_0002);
        axi_wr(`PPC_OFF_IRQ_CLEAR, 32'h0000_0002);
        rd_chk(`PPC_OFF_IRQ_STATUS, 32'h0000_0000);
        $display("latched flags done");
    endtask
    task automatic t_disc();
        energy_cmd <= 1'b1;
        axi_wr(`PPC_OFF_POWER, 32'h0000_00ad);
        check(phy_ctrl.link_disconnect, 1'b1);
        repeat (8) @(posedge aclk);
        rd_chk(`PPC_OFF_POWER, 32'h0000_01bd);
        rd_chk(`PPC_OFF_POWER, 32'h0000_01bd);
        energy_cmd <= 1'b0;
        axi_wr(`PPC_OFF_POWER, 32'h0000_008d);
        axi_wr(16'h0e50, 32'h0000_ffff);
        check(last_resp, `PPC_RESP_SLVERR);
        rd_chk(16'h0e50, 32'h0000_0000);
        check(last_resp, `PPC_RESP_SLVERR);
        $display("disconnect and unmapped done");
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_nvm();
        t_eee();
        t_power();
        t_latch_irq();
        t_disc();
        end_sim();
    end
endmodule
